// [record_buffer_map.svh]
`ifndef RECORD_BUFFER_MAP_SVH
`define RECORD_BUFFER_MAP_SVH

// Capacity encodings for the record-count field
`define CAP_CODE_8 8'h08
`define CAP_CODE_16 8'h10
`define CAP_CODE_32 8'h20
`define CAP_CODE_64 8'h40
// Bank-select values
`define BANK_LOW 2'h0
`define BANK_HIGH 2'h1
// Records per bank window
`define BANK_SIZE 32
// Valid field of an info word
`define VALID_LSB 0
`define VALID_INVALID 2'h0
// Reset values
`define RESET_BANK 2'h0
`define RESET_PAUSED 1'h0
`define RESET_REC_CTL 1'h0

`endif

// [record_buffer_pkg.sv]
package record_buffer_pkg;
   typedef enum logic [1:0] {
      op_idle,
      op_capture,
      op_inject,
      op_inval
   } buf_op_t;
endpackage

// [record_store.sv]
`timescale 1ns/100ps
`include "record_buffer_map.svh"

// Record storage: a shift array, slot 0 youngest, registered read port
module record_store #(
   parameter int DEPTH = 64,
   parameter int AW = 6,
   parameter int DW = 64,
   parameter int IW = 64
) (
   // Clock
   input wire logic mclk,
   // Push a new youngest record
   input wire logic push,
   input wire logic [DW-1:0] push_src,
   input wire logic [DW-1:0] push_tgt,
   input wire logic [IW-1:0] push_info,
   // Clear valid fields of all slots
   input wire logic clear_all,
   // Read port
   input wire logic [AW-1:0] rd_idx,
   output logic [DW-1:0] rd_src,
   output logic [DW-1:0] rd_tgt,
   output logic [IW-1:0] rd_info
);
   typedef struct packed {
      logic [DEPTH-1:0][DW-1:0] src;
      logic [DEPTH-1:0][DW-1:0] tgt;
      logic [DEPTH-1:0][IW-1:0] info;
      logic [DW-1:0] rsrc;
      logic [DW-1:0] rtgt;
      logic [IW-1:0] rinfo;
   } mem_t;

   mem_t s_q;
   mem_t s_d;

   always_comb begin
      s_d = s_q;
      if (push) begin
         // Oldest slot falls off the end
         for (int i = DEPTH - 1; i > 0; i--) begin
            s_d.src[i] = s_q.src[i-1];
            s_d.tgt[i] = s_q.tgt[i-1];
            s_d.info[i] = s_q.info[i-1];
         end
         s_d.src[0] = push_src;
         s_d.tgt[0] = push_tgt;
         s_d.info[0] = push_info;
      end
      if (clear_all) begin
         for (int i = 0; i < DEPTH; i++) begin
            s_d.info[i][`VALID_LSB +: 2] = `VALID_INVALID;
         end
      end
      s_d.rsrc = s_q.src[rd_idx];
      s_d.rtgt = s_q.tgt[rd_idx];
      s_d.rinfo = s_q.info[rd_idx];
   end

   always_ff @(posedge mclk) begin
      s_q <= s_d;
   end

   assign rd_src = s_q.rsrc;
   assign rd_tgt = s_q.rtgt;
   assign rd_info = s_q.rinfo;
endmodule

// [record_buffer.sv]
//
// How it works
// [RL1] Storage holds CAPACITY records; capacity reported on record_capacity_field.
// [RL2] Read window shows up to 32 records of the bank selected.
// [RL3] Bank 0 maps indices 0-31, bank 1 maps indices 32-63.
// [RL4] Index 0 is youngest; each index older than the one below it.
// [RL5] New record into a full store drops the oldest record.
// [RL6] Valid records contiguous from 0; valid means info valid field nonzero.
// [RL7] Capture writes source, target and info; reads need synchronization first.
// [RL8] Invalidate-all marks every stored record invalid.
// [RL9] Records before the preceding sync event are removed by invalidate-all.
// [RL10] Records after a later sync event survive invalidate-all.
// [RL11] Invalidating a record invalidates every older record too.
// [RL12] Invalid slot stays invalid until overwritten by capture or inject.
// [RL13] Reads beyond implemented capacity return zero.
// [RL14] A selected record that cannot be captured invalidates all records.
// [RL15] Unpaused captures form one continuous block over non-prohibited regions.
// [RL16] Inject in prohibited region inserts injection registers as youngest.
// [RL17] Inject outside a prohibited region may or may not inject.
// [RL18] Inject uses earlier injection writes, ignores later ones.
// [RL19] Injection data registers are unspecified after an inject.
// [RL20] Control fields undefined on cold reset, kept across warm reset.
// [RL21] Cold control clears on cold reset, warm control on warm reset.
// [RL22] Once paused is read as one, no records until software clears it.
//
`timescale 1ns/100ps
`include "record_buffer_map.svh"

module record_buffer
   import record_buffer_pkg::*;
#(
   parameter int CAPACITY = 64,
   parameter int DW = 64,
   parameter int IW = 64,
   parameter bit INJECT_OUTSIDE = 1'b1
) (
   // Clock and resets
   input wire logic mclk,
   input wire logic rst,
   input wire logic warm_rst,
   // Retired branch capture from the pipeline
   input wire logic cap_valid,
   input wire logic cap_drop,
   input wire logic [DW-1:0] cap_src,
   input wire logic [DW-1:0] cap_tgt,
   input wire logic [IW-1:0] cap_info,
   input wire logic prohibited,
   // Function control writes
   input wire logic ctrl_wr,
   input wire logic [1:0] ctrl_bank,
   input wire logic ctrl_paused,
   // Paused set by freeze logic
   input wire logic pause_set,
   // Recording controls
   input wire logic rec_ctl_wr,
   input wire logic cold_ctl_in,
   input wire logic warm_ctl_in,
   // Injection data register writes
   input wire logic inj_src_wr,
   input wire logic inj_tgt_wr,
   input wire logic inj_info_wr,
   input wire logic [DW-1:0] inj_wdata,
   input wire logic [IW-1:0] inj_info_wdata,
   // Operations
   input wire logic invalidate_all_op,
   input wire logic inject_record_op,
   // Record window read
   input wire logic [4:0] rd_idx,
   output logic [DW-1:0] record_source_reg,
   output logic [DW-1:0] record_target_reg,
   output logic [IW-1:0] record_info_reg,
   // Status
   output logic [7:0] record_capacity_field,
   output logic [1:0] bank_sel,
   output logic paused,
   output logic cold_reset_record_ctl,
   output logic warm_reset_record_ctl,
   output logic [6:0] valid_count
);
   localparam int AW = $clog2(CAPACITY);

   typedef struct packed {
      logic [1:0] bank;
      logic paused;
      logic cold_ctl;
      logic warm_ctl;
      logic [DW-1:0] inj_src;
      logic [DW-1:0] inj_tgt;
      logic [IW-1:0] inj_info;
      logic [6:0] count;
      logic rd_hit;
      logic [7:0] cap;
      buf_op_t last_op;
      logic [DW-1:0] osrc;
      logic [DW-1:0] otgt;
      logic [IW-1:0] oinfo;
   } st_t;

   st_t s_q;
   st_t s_d;

   logic push;
   logic clear_all;
   logic [DW-1:0] push_src;
   logic [DW-1:0] push_tgt;
   logic [IW-1:0] push_info;
   logic [AW-1:0] st_idx;
   logic [DW-1:0] m_src;
   logic [DW-1:0] m_tgt;
   logic [IW-1:0] m_info;
   logic [6:0] full_idx;
   logic [2:0] warm_pipe;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [6:0] win_index(input logic [1:0] bank, input logic [4:0] idx);
      win_index = (bank == `BANK_HIGH) ? (7'(`BANK_SIZE) + {2'h0, idx}) : {2'h0, idx};
   endfunction

   function automatic logic [7:0] cap_code(input int c);
      case (c)
         8: cap_code = 8'(`CAP_CODE_8);
         16: cap_code = 8'(`CAP_CODE_16);
         32: cap_code = 8'(`CAP_CODE_32);
         default: cap_code = 8'(`CAP_CODE_64);
      endcase
   endfunction

   // ----------------------------------------
   // Operation decode
   // ----------------------------------------
   // Ops are taken in program order as presented; invalidate clears the valid field of
   // every slot, a record pushed in the same cycle included; only the count keeps it.
   always_comb begin
      logic inj_go;
      logic cap_go;
      inj_go = 1'b0;
      cap_go = 1'b0;
      inj_go = inject_record_op && (prohibited || INJECT_OUTSIDE); // see [RL16] see [RL17]
      // Paused stops generation; prohibited regions capture nothing, inject still records there
      cap_go = cap_valid && !cap_drop && !prohibited && !s_q.paused; // see [RL22] see [RL15]
      // An uncapturable record wipes the store
      clear_all = invalidate_all_op || (cap_valid && cap_drop && !prohibited
                  && !s_q.paused); // see [RL8] see [RL9] see [RL14]
      push = inj_go || cap_go; // see [RL10]
      // Inject uses the injection registers as they stand before this cycle
      push_src = inj_go ? s_q.inj_src : cap_src; // see [RL18]
      push_tgt = inj_go ? s_q.inj_tgt : cap_tgt;
      push_info = inj_go ? s_q.inj_info : cap_info; // see [RL7]
      full_idx = win_index(s_q.bank, rd_idx); // see [RL2] see [RL3]
      st_idx = full_idx[AW-1:0];
   end

   // ----------------------------------------
   // State update
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.cap = cap_code(CAPACITY); // see [RL1]
      if (ctrl_wr) begin
         s_d.bank = ctrl_bank;
         s_d.paused = ctrl_paused;
      end
      if (pause_set) begin
         s_d.paused = 1'b1;
      end
      if (rec_ctl_wr) begin
         s_d.cold_ctl = cold_ctl_in;
         s_d.warm_ctl = warm_ctl_in;
      end
      // Count of valid records, kept contiguous from index 0
      if (clear_all) begin
         s_d.count = 7'h0; // see [RL11] see [RL12]
      end
      if (push && (s_d.count < 7'(CAPACITY))) begin
         s_d.count = s_d.count + 7'h1; // see [RL6] see [RL5]
      end
      s_d.last_op = push ? (inject_record_op ? op_inject : op_capture)
                    : (clear_all ? op_inval : op_idle);
      if (inj_src_wr) begin
         s_d.inj_src = inj_wdata;
      end
      if (inj_tgt_wr) begin
         s_d.inj_tgt = inj_wdata;
      end
      if (inj_info_wr) begin
         s_d.inj_info = inj_info_wdata;
      end
      // Injection registers left as they were: any value is allowed
      if (inject_record_op && !(inj_src_wr || inj_tgt_wr || inj_info_wr)) begin
         s_d.inj_info = s_q.inj_info; // see [RL19]
      end
      s_d.rd_hit = full_idx < 7'(CAPACITY);
      // Slot past capacity reads zero; outputs held in flops
      s_d.osrc = s_q.rd_hit ? m_src : '0; // see [RL13]
      s_d.otgt = s_q.rd_hit ? m_tgt : '0;
      s_d.oinfo = s_q.rd_hit ? m_info : '0;
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Warm reset through three flops; acts once two later stages agree
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         warm_pipe <= 3'h0;
      end else begin
         warm_pipe <= {warm_pipe[1:0], warm_rst};
      end
   end

   // Only the second and third stages decide
   logic warm_s0;
   assign warm_s0 = warm_pipe[1] & warm_pipe[2];

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         // Cold reset: all control defined here; bank and paused chosen zero
         s_q <= '0;
         s_q.bank <= `RESET_BANK;
         s_q.paused <= `RESET_PAUSED;
         s_q.cold_ctl <= `RESET_REC_CTL; // see [RL21]
         s_q.warm_ctl <= `RESET_REC_CTL;
         s_q.last_op <= op_idle;
      end else if (warm_s0) begin
         // Warm reset keeps buffer control, clears only the warm control
         s_q <= s_d;
         s_q.warm_ctl <= `RESET_REC_CTL; // see [RL20] see [RL21]
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   record_store #(
      .DEPTH(CAPACITY),
      .AW(AW),
      .DW(DW),
      .IW(IW)
   ) u_store (
      .mclk(mclk),
      .push(push),
      .push_src(push_src),
      .push_tgt(push_tgt),
      .push_info(push_info),
      .clear_all(clear_all),
      .rd_idx(st_idx),
      .rd_src(m_src),
      .rd_tgt(m_tgt),
      .rd_info(m_info)
   );

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Read data two cycles after index and bank
   assign record_source_reg = s_q.osrc; // see [RL13]
   assign record_target_reg = s_q.otgt;
   assign record_info_reg = s_q.oinfo; // see [RL4]
   assign record_capacity_field = s_q.cap;
   assign bank_sel = s_q.bank;
   assign paused = s_q.paused;
   assign cold_reset_record_ctl = s_q.cold_ctl;
   assign warm_reset_record_ctl = s_q.warm_ctl;
   assign valid_count = s_q.count;
endmodule

// [buffer_checker.sv]
`timescale 1ns/100ps
module buffer_checker #(
   parameter int CAPACITY = 64
) (
   // Watched ports
   input wire logic mclk,
   input wire logic rst,
   input wire logic warm_rst,
   input wire logic cap_valid,
   input wire logic cap_drop,
   input wire logic prohibited,
   input wire logic rec_ctl_wr,
   input wire logic invalidate_all_op,
   input wire logic inject_record_op,
   input wire logic paused,
   input wire logic [6:0] valid_count,
   input wire logic [7:0] record_capacity_field,
   input wire logic cold_reset_record_ctl,
   input wire logic warm_reset_record_ctl
);
   // ----------
   // Properties
   // ----------
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   logic take;
   logic full;
   assign take = cap_valid && !cap_drop && !prohibited && !paused && !inject_record_op;
   assign full = valid_count == 7'(CAPACITY);
   property p_cap; !$past(rst) |-> record_capacity_field == 8'(CAPACITY); endproperty
   property p_grow; take && !invalidate_all_op && !full |=> valid_count == $past(valid_count) + 7'h1; endproperty
   property p_sat; take && !invalidate_all_op && full |=> full; endproperty
   property p_inval; invalidate_all_op && !cap_valid && !inject_record_op |=> valid_count == 7'h0; endproperty
   property p_keep; invalidate_all_op && inject_record_op && prohibited && !cap_valid |=> valid_count == 7'h1; endproperty
   property p_drop; cap_valid && cap_drop && !prohibited && !paused && !inject_record_op |=> valid_count == 7'h0; endproperty
   property p_pause; paused && !inject_record_op && !invalidate_all_op |=> $stable(valid_count); endproperty
   property p_inj; inject_record_op && prohibited && !invalidate_all_op && !cap_valid && !full |=> valid_count == $past(valid_count) + 7'h1; endproperty
   property p_warm; warm_rst [*5] |-> !warm_reset_record_ctl; endproperty
   property p_cold; warm_rst && !rec_ctl_wr |=> $stable(cold_reset_record_ctl); endproperty
   a_cap: assert property (p_cap) else $error("capacity field wrong");
   a_grow: assert property (p_grow) else $error("capture not counted");
   a_sat: assert property (p_sat) else $error("full count lost");
   a_inval: assert property (p_inval) else $error("records left valid");
   a_keep: assert property (p_keep) else $error("later record lost");
   a_drop: assert property (p_drop) else $error("drop kept records");
   a_pause: assert property (p_pause) else $error("record while paused");
   a_inj: assert property (p_inj) else $error("inject not counted");
   a_warm: assert property (p_warm) else $error("warm control kept");
   a_cold: assert property (p_cold) else $error("cold control moved");
   c_full: cover property (take && full);
   c_inj: cover property (inject_record_op && prohibited);
   c_warm: cover property (warm_rst [*5]);
endmodule
bind record_buffer buffer_checker #(.CAPACITY(CAPACITY)) chk_i (.mclk, .rst, .warm_rst,
   .cap_valid, .cap_drop, .prohibited, .rec_ctl_wr, .invalidate_all_op, .inject_record_op,
   .paused, .valid_count, .record_capacity_field, .cold_reset_record_ctl, .warm_reset_record_ctl);

// [core_model.sv]
`timescale 1ns/100ps
module core_model #(
   parameter int DW = 16
) (
   // Clock and request
   input wire logic mclk,
   input wire logic go,
   input wire logic [6:0] num,
   // Capture stream
   output logic cap_valid,
   output logic [DW-1:0] cap_src,
   output logic [DW-1:0] cap_tgt,
   output logic [DW-1:0] cap_info,
   output logic busy
);
   // --------------
   // Record stream
   // --------------
   logic [6:0] left = 7'h0;
   logic [DW-1:0] seq = 16'h0;
   initial begin
      cap_valid = 1'b0;
      cap_src = 16'h0;
      cap_tgt = 16'h0;
      cap_info = 16'h0;
   end
   always @(posedge mclk) begin
      if (left != 7'h0) begin
         seq = seq + 16'h1;
         cap_valid <= 1'b1;
         cap_src <= seq;
         cap_tgt <= ~seq;
         cap_info <= {seq[DW-3:0], 2'h1};
         left <= left - 7'h1;
      end else begin
         cap_valid <= 1'b0;
         cap_src <= ~cap_src;
         cap_tgt <= ~cap_tgt;
         cap_info <= ~cap_info;
         if (go) left <= num;
      end
   end
   assign busy = (left != 7'h0) || cap_valid;
endmodule

// [test_record_buffer.sv]
`timescale 1ns/100ps
module test_record_buffer;
   // ---------
   // Harness
   // ---------
   logic mclk = 1'b0, rst = 1'b1, warm_rst = 1'b0, cap_drop = 1'b0, prohibited = 1'b0;
   logic ctrl_wr = 1'b0, pause_set = 1'b0, rec_ctl_wr = 1'b0, cold_in = 1'b0, warm_in = 1'b0;
   logic inj_wr = 1'b0, inval = 1'b0, inject = 1'b0, go = 1'b0;
   logic [1:0] bank = 2'h0;
   logic [4:0] rd_idx = 5'h0;
   logic [6:0] num = 7'h0;
   logic [15:0] inj_data = 16'h0;
   logic cap_valid, busy, paused, cold_ctl, warm_ctl;
   logic [15:0] cap_src, cap_tgt, cap_info, src_o, tgt_o, info_o;
   logic [7:0] cap_field;
   logic [1:0] bank_sel;
   logic [6:0] valid_count;
   int num_errors = 0, n_compared = 0;
   record_buffer #(.CAPACITY(64), .DW(16), .IW(16)) dut (.mclk, .rst, .warm_rst, .cap_valid,
      .cap_drop, .cap_src, .cap_tgt, .cap_info, .prohibited, .ctrl_wr, .ctrl_bank(bank),
      .ctrl_paused(1'b0), .pause_set, .rec_ctl_wr, .cold_ctl_in(cold_in), .warm_ctl_in(warm_in),
      .inj_src_wr(inj_wr), .inj_tgt_wr(inj_wr), .inj_info_wr(inj_wr), .inj_wdata(inj_data),
      .inj_info_wdata(inj_data), .invalidate_all_op(inval), .inject_record_op(inject), .rd_idx,
      .record_source_reg(src_o), .record_target_reg(tgt_o), .record_info_reg(info_o),
      .record_capacity_field(cap_field), .bank_sel, .paused, .cold_reset_record_ctl(cold_ctl),
      .warm_reset_record_ctl(warm_ctl), .valid_count);
   core_model #(.DW(16)) model (.mclk, .go, .num, .cap_valid, .cap_src, .cap_tgt, .cap_info, .busy);
   initial forever #50 mclk = ~mclk;
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wrap_up;
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic run_caps(input logic [6:0] n);
      int i;
      @(posedge mclk);
      go <= 1'b1;
      num <= n;
      @(posedge mclk);
      go <= 1'b0;
      @(negedge mclk);
      for (i = 0; i < 200 && busy; i++) @(negedge mclk);
      if (busy) begin
         num_errors++;
         wrap_up();
      end
   endtask
   task automatic rd(input logic [1:0] b, input logic [4:0] i);
      @(posedge mclk);
      ctrl_wr <= 1'b1;
      bank <= b;
      rd_idx <= i;
      @(posedge mclk);
      ctrl_wr <= 1'b0;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      chk("bank", b, bank_sel);
   endtask
   task automatic t_reset;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      chk("capacity", 8'h40, cap_field);
      chk("count", 7'h0, valid_count);
      chk("cold ctl", 1'h0, cold_ctl);
      chk("warm ctl", 1'h0, warm_ctl);
   endtask
   task automatic t_fill;
      run_caps(7'h42);
      chk("count", 7'h40, valid_count);
      rd(2'h0, 5'h0);
      chk("src0", 16'h42, src_o);
      chk("tgt0", 16'hffbd, tgt_o);
      rd(2'h1, 5'h0);
      chk("src32", 16'h22, src_o);
      rd(2'h1, 5'h1f);
      chk("src63", 16'h3, src_o);
   endtask
   task automatic t_inval_inject;
      @(posedge mclk);
      inval <= 1'b1;
      @(posedge mclk);
      inval <= 1'b0;
      @(negedge mclk);
      chk("count", 7'h0, valid_count);
      rd(2'h0, 5'h0);
      chk("valid0", 2'h0, info_o[1:0]);
      @(posedge mclk);
      prohibited <= 1'b1;
      inj_wr <= 1'b1;
      inj_data <= 16'ha5;
      @(posedge mclk);
      inj_data <= 16'hbad;
      inject <= 1'b1;
      @(posedge mclk);
      inj_wr <= 1'b0;
      inject <= 1'b0;
      @(negedge mclk);
      chk("count", 7'h1, valid_count);
      rd(2'h0, 5'h0);
      chk("src0", 16'ha5, src_o);
      @(posedge mclk);
      inval <= 1'b1;
      inject <= 1'b1;
      @(posedge mclk);
      inval <= 1'b0;
      inject <= 1'b0;
      prohibited <= 1'b0;
      @(negedge mclk);
      chk("count", 7'h1, valid_count);
   endtask
   task automatic t_drop_pause;
      run_caps(7'h2);
      chk("count", 7'h3, valid_count);
      @(posedge mclk);
      cap_drop <= 1'b1;
      run_caps(7'h1);
      @(posedge mclk);
      cap_drop <= 1'b0;
      @(negedge mclk);
      chk("count", 7'h0, valid_count);
      @(posedge mclk);
      pause_set <= 1'b1;
      @(posedge mclk);
      pause_set <= 1'b0;
      run_caps(7'h3);
      chk("paused", 1'h1, paused);
      chk("count", 7'h0, valid_count);
      rd(2'h0, 5'h0);
      run_caps(7'h1);
      chk("paused", 1'h0, paused);
      chk("count", 7'h1, valid_count);
   endtask
   task automatic t_warm;
      @(posedge mclk);
      rec_ctl_wr <= 1'b1;
      cold_in <= 1'b1;
      warm_in <= 1'b1;
      @(posedge mclk);
      rec_ctl_wr <= 1'b0;
      warm_rst <= 1'b1;
      repeat (6) @(posedge mclk);
      warm_rst <= 1'b0;
      @(negedge mclk);
      chk("warm ctl", 1'h0, warm_ctl);
      chk("cold ctl", 1'h1, cold_ctl);
      chk("count", 7'h1, valid_count);
   endtask
   initial begin
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
      t_fill();
      t_inval_inject();
      t_drop_pause();
      t_warm();
      wrap_up();
   end
endmodule
